// File: hdl/stp_gate.sv
// Purpose: per-port spanning tree state gate with APB registers
// Assumes: inputs synchronous to core_clk_in; zero-wait APB slave
// Notes: state codes 0 disabled, 1 blocking, 2 listening, 3 learning, 4 forwarding
// Notes on behaviour
// - link down puts the port into disabled and reports it
// - blocking: no forwarding, no address learning
// - listening: no forwarding, no address learning
// - learning: no forwarding, but source addresses are learned
// - forwarding: traffic forwarded and addresses learned
// - after boot reset every port is blocking
// - blocking may go only to listening or disabled
// - listening may go only to learning or disabled
// - learning may go only to forwarding or disabled
// - forwarding may go only to disabled
// - disabled may go only back to blocking
// - with spanning tree on, port state decides forwarding action
// - steady flag shown when no topology change is in progress
// - per-port edge flag kept and readable
// - per-port point-to-point flag reflects real link type
// - lower path cost ports preferred to stay unblocked
// - configuration frames spaced by at least the hello time
// - own bridge identifier is priority joined with MAC address
// - root identifier of priority and MAC held and reported
`include "stp_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module stp_gate
    import stp_pkg::*;
#(
    parameter int NUM_PORTS = 8,
    parameter int TICK_CYCLES = `STP_TICK_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    input wire logic [NUM_PORTS-1:0] link_up_in,
    input wire logic [NUM_PORTS-1:0] point_to_point_link_flag_in,
    input wire logic bpdu_tx_req_in,
    output logic bpdu_tx_grant_out,
    output logic [3*NUM_PORTS-1:0] port_state_out,
    output logic [NUM_PORTS-1:0] fwd_en_out,
    output logic [NUM_PORTS-1:0] learn_en_out,
    output logic [NUM_PORTS-1:0] edge_port_out,
    output logic [NUM_PORTS-1:0] point_to_point_link_flag_out,
    output logic [63:0] own_bridge_identifier_out,
    output logic [63:0] tree_root_identifier_out,
    output logic topo_steady_out,
    output logic is_root_out,
    output logic block_valid_out,
    output logic [2:0] block_port_out
);

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [NUM_PORTS-1:0] port_en;
    logic [NUM_PORTS-1:0] next_port_en;
    logic [15:0] br_prio;
    logic [15:0] next_br_prio;
    logic [47:0] br_mac;
    logic [47:0] next_br_mac;
    logic [15:0] root_prio;
    logic [15:0] next_root_prio;
    logic [47:0] root_mac;
    logic [47:0] next_root_mac;
    logic tc_active;
    logic next_tc_active;
    logic [NUM_PORTS-1:0] edge_flag;
    logic [NUM_PORTS-1:0] next_edge_flag;
    logic [7:0] hello_s;
    logic [7:0] next_hello_s;
    logic [31:0] cost [NUM_PORTS];
    logic [31:0] next_cost [NUM_PORTS];
    logic req_pulse;
    logic next_req_pulse;
    logic [2:0] req_state;
    logic [2:0] next_req_state;
    logic [2:0] req_port;
    logic [2:0] next_req_port;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic slverr;
    logic next_slverr;

    logic setup;
    logic wr_en;
    logic cost_hit;
    logic [2:0] cost_idx;
    logic map_hit;
    logic [31:0] read_mux;
    logic [3*NUM_PORTS-1:0] state_vec;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    // every access completes in its first access cycle
    assign pready_out = psel_in & penable_in;
    assign setup = psel_in & ~penable_in;
    assign wr_en = psel_in & penable_in & pwrite_in & ~slverr;
    assign cost_hit = (paddr_in >= `STP_OFS_COST_BASE)
        && (paddr_in < 8'(`STP_OFS_COST_BASE + 4 * NUM_PORTS))
        && (paddr_in[1:0] == 2'h0);
    assign cost_idx = 3'((paddr_in - `STP_OFS_COST_BASE) >> 2);

    always_comb
    begin
        map_hit = 1'b1;
        read_mux = 32'h0000_0000;
        case (paddr_in)
            `STP_OFS_PORT_EN: read_mux[NUM_PORTS-1:0] = port_en;
            `STP_OFS_STATE_REQ:
            begin
                read_mux[`STP_REQ_STATE_LSB +: 3] = req_state;
                read_mux[`STP_REQ_PORT_LSB +: 3] = req_port;
            end
            `STP_OFS_PORT_STATE: read_mux[3*NUM_PORTS-1:0] = state_vec;
            `STP_OFS_BR_PRIO: read_mux[15:0] = br_prio;
            `STP_OFS_BR_MAC_HI: read_mux[15:0] = br_mac[47:32];
            `STP_OFS_BR_MAC_LO: read_mux = br_mac[31:0];
            `STP_OFS_ROOT_PRIO: read_mux[15:0] = root_prio;
            `STP_OFS_ROOT_MAC_HI: read_mux[15:0] = root_mac[47:32];
            `STP_OFS_ROOT_MAC_LO: read_mux = root_mac[31:0];
            `STP_OFS_TOPO: read_mux[1:0] = {~tc_active, tc_active};
            `STP_OFS_EDGE: read_mux[NUM_PORTS-1:0] = edge_flag;
            `STP_OFS_P2P: read_mux[NUM_PORTS-1:0] = point_to_point_link_flag_in;
            `STP_OFS_HELLO: read_mux[7:0] = hello_s;
            `STP_OFS_STATUS:
            begin
                read_mux[NUM_PORTS-1:0] = link_up_in;
                read_mux[8 +: NUM_PORTS] = fwd_en_out;
                read_mux[16 +: NUM_PORTS] = learn_en_out;
                read_mux[24] = is_root_out;
                read_mux[25] = block_valid_out;
                read_mux[28 +: 3] = block_port_out;
            end
            default:
            begin
                if (cost_hit)
                begin
                    read_mux = cost[cost_idx];
                end
                else
                begin
                    map_hit = 1'b0;
                end
            end
        endcase
    end

    // read data and error are caught in the setup cycle
    always_comb
    begin
        next_rdata = rdata;
        next_slverr = slverr;
        if (setup)
        begin
            next_rdata = pwrite_in ? 32'h0000_0000 : read_mux;
            next_slverr = ~map_hit;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rdata <= 32'h0000_0000;
            slverr <= 1'b0;
        end
        else
        begin
            rdata <= next_rdata;
            slverr <= next_slverr;
        end
    end

    assign prdata_out = rdata;
    assign pslverr_out = slverr & pready_out;

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_comb
    begin
        next_port_en = port_en;
        next_br_prio = br_prio;
        next_br_mac = br_mac;
        next_root_prio = root_prio;
        next_root_mac = root_mac;
        next_tc_active = tc_active;
        next_edge_flag = edge_flag;
        next_hello_s = hello_s;
        next_cost = cost;
        next_req_pulse = 1'b0;
        next_req_state = req_state;
        next_req_port = req_port;
        if (wr_en)
        begin
            case (paddr_in)
                `STP_OFS_PORT_EN: next_port_en = pwdata_in[NUM_PORTS-1:0];
                `STP_OFS_STATE_REQ:
                begin
                    next_req_pulse = 1'b1;
                    next_req_state = pwdata_in[`STP_REQ_STATE_LSB +: 3];
                    next_req_port = pwdata_in[`STP_REQ_PORT_LSB +: 3];
                end
                `STP_OFS_BR_PRIO: next_br_prio = pwdata_in[15:0];
                `STP_OFS_BR_MAC_HI: next_br_mac[47:32] = pwdata_in[15:0];
                `STP_OFS_BR_MAC_LO: next_br_mac[31:0] = pwdata_in;
                `STP_OFS_ROOT_PRIO: next_root_prio = pwdata_in[15:0];
                `STP_OFS_ROOT_MAC_HI: next_root_mac[47:32] = pwdata_in[15:0];
                `STP_OFS_ROOT_MAC_LO: next_root_mac[31:0] = pwdata_in;
                `STP_OFS_TOPO: next_tc_active = pwdata_in[0];
                `STP_OFS_EDGE: next_edge_flag = pwdata_in[NUM_PORTS-1:0];
                `STP_OFS_HELLO: next_hello_s = pwdata_in[7:0];
                default:
                begin
                    if (cost_hit)
                    begin
                        next_cost[cost_idx] = pwdata_in;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            port_en <= NUM_PORTS'(`STP_RST_PORT_EN);
            br_prio <= `STP_RST_PRIO;
            br_mac <= 48'h0000_0000_0000;
            root_prio <= `STP_RST_PRIO;
            root_mac <= 48'h0000_0000_0000;
            tc_active <= 1'b0;
            edge_flag <= '0;
            hello_s <= `STP_RST_HELLO;
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                cost[i] <= `STP_RST_COST;
            end
            req_pulse <= 1'b0;
            req_state <= 3'h0;
            req_port <= 3'h0;
        end
        else
        begin
            port_en <= next_port_en;
            br_prio <= next_br_prio;
            br_mac <= next_br_mac;
            root_prio <= next_root_prio;
            root_mac <= next_root_mac;
            tc_active <= next_tc_active;
            edge_flag <= next_edge_flag;
            hello_s <= next_hello_s;
            cost <= next_cost;
            req_pulse <= next_req_pulse;
            req_state <= next_req_state;
            req_port <= next_req_port;
        end
    end

    // ----------------------------------------
    // per-port state machines
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++)
        begin : gen_port
            stp_state_e st;
            stp_port_fsm u_fsm (
                .core_clk_in(core_clk_in),
                .rst_n_in(rst_n_in),
                .link_up_in(link_up_in[g]),
                .stp_en_in(port_en[g]),
                .req_in(req_pulse && (req_port == 3'(g))),
                .req_state_in(req_state),
                .state_out(st),
                .fwd_en_out(fwd_en_out[g]),
                .learn_en_out(learn_en_out[g])
            );
            assign state_vec[3*g +: 3] = st;
        end
    endgenerate

    assign port_state_out = state_vec;

    // ----------------------------------------
    // hello spacing
    // ----------------------------------------
    stp_hello_gate #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_hello (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .hello_s_in(hello_s),
        .tx_req_in(bpdu_tx_req_in),
        .tx_grant_out(bpdu_tx_grant_out)
    );

    // ----------------------------------------
    // loop resolution hint
    // ----------------------------------------
    // suggests the costliest non-edge forwarding port to block; a hint only, the
    // protocol engine still issues the state change itself
    logic cand_valid;
    logic next_cand_valid;
    logic [2:0] cand_port;
    logic [2:0] next_cand_port;
    logic [31:0] cand_cost;

    always_comb
    begin
        next_cand_valid = 1'b0;
        next_cand_port = 3'h0;
        cand_cost = 32'h0000_0000;
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            if (port_en[i] && fwd_en_out[i] && !edge_flag[i]
                && (!next_cand_valid || cost[i] >= cand_cost))
            begin
                next_cand_valid = 1'b1;
                next_cand_port = 3'(i);
                cand_cost = cost[i];
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cand_valid <= 1'b0;
            cand_port <= 3'h0;
        end
        else
        begin
            cand_valid <= next_cand_valid;
            cand_port <= next_cand_port;
        end
    end

    assign block_valid_out = cand_valid;
    assign block_port_out = cand_port;

    // ----------------------------------------
    // bridge status
    // ----------------------------------------
    assign own_bridge_identifier_out = {br_prio, br_mac};
    assign tree_root_identifier_out = {root_prio, root_mac};
    assign is_root_out = (own_bridge_identifier_out == tree_root_identifier_out);
    assign topo_steady_out = ~tc_active;
    assign edge_port_out = edge_flag;
    assign point_to_point_link_flag_out = point_to_point_link_flag_in;

endmodule

`default_nettype wire

// File: hdl/stp_defines.svh
// Purpose: constants for the spanning tree port state gate
// Assumes: APB with 32-bit data, one word per register
// Notes: offsets are byte addresses
`ifndef STP_DEFINES_SVH
`define STP_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define STP_OFS_PORT_EN      8'h00
`define STP_OFS_STATE_REQ    8'h04
`define STP_OFS_PORT_STATE   8'h08
`define STP_OFS_BR_PRIO      8'h0C
`define STP_OFS_BR_MAC_HI    8'h10
`define STP_OFS_BR_MAC_LO    8'h14
`define STP_OFS_ROOT_PRIO    8'h18
`define STP_OFS_ROOT_MAC_HI  8'h1C
`define STP_OFS_ROOT_MAC_LO  8'h20
`define STP_OFS_TOPO         8'h24
`define STP_OFS_EDGE         8'h28
`define STP_OFS_P2P          8'h2C
`define STP_OFS_HELLO        8'h30
`define STP_OFS_STATUS       8'h34
`define STP_OFS_COST_BASE    8'h40

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define STP_REQ_STATE_LSB    0
`define STP_REQ_PORT_LSB     4
`define STP_RST_PORT_EN      8'hFF
`define STP_RST_PRIO         16'h8000
`define STP_RST_HELLO        8'h02
`define STP_RST_COST         32'h0000_0004
`define STP_PRIO_W           16
`define STP_MAC_HI_W         16

// ----------------------------------------
// timing
// ----------------------------------------
`define STP_CLK_HZ           50000000
`define STP_TICK_S           1
`define STP_TICK_CYCLES      (`STP_CLK_HZ * `STP_TICK_S)

`endif

// File: hdl/stp_pkg.sv
// Purpose: shared types of the spanning tree port state gate
// Assumes: nothing beyond the defines header
// Notes: state codes are the 3-bit values reported to software
package stp_pkg;

    typedef enum logic [2:0] {
        STP_DISABLED   = 3'h0,
        STP_BLOCKING   = 3'h1,
        STP_LISTENING  = 3'h2,
        STP_LEARNING   = 3'h3,
        STP_FORWARDING = 3'h4
    } stp_state_e;

endpackage

// File: hdl/stp_port_fsm.sv
// Purpose: state machine of one switch port
// Assumes: request pulse lasts one cycle
// Notes: illegal requests leave the state alone
`timescale 1ns/1ns
`default_nettype none

module stp_port_fsm
    import stp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic link_up_in,
    input wire logic stp_en_in,
    input wire logic req_in,
    input wire logic [2:0] req_state_in,
    output stp_state_e state_out,
    output logic fwd_en_out,
    output logic learn_en_out
);

    stp_state_e state;
    stp_state_e next_state;
    stp_state_e req;

    assign req = stp_state_e'(req_state_in);

    always_comb
    begin
        next_state = state;
        if (!link_up_in)
        begin
            next_state = STP_DISABLED;
        end
        else if (req_in)
        begin
            case (state)
                STP_BLOCKING:
                begin
                    if (req == STP_LISTENING || req == STP_DISABLED) next_state = req;
                end
                STP_LISTENING:
                begin
                    if (req == STP_LEARNING || req == STP_DISABLED) next_state = req;
                end
                STP_LEARNING:
                begin
                    if (req == STP_FORWARDING || req == STP_DISABLED) next_state = req;
                end
                STP_FORWARDING:
                begin
                    if (req == STP_DISABLED) next_state = req;
                end
                STP_DISABLED:
                begin
                    if (req == STP_BLOCKING) next_state = req;
                end
                default:
                begin
                    next_state = STP_BLOCKING;
                end
            endcase
            // any other request falls through unchanged
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= STP_BLOCKING;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign state_out = state;

    // without spanning tree a port passes traffic whenever its link is up
    always_comb
    begin
        if (!stp_en_in)
        begin
            fwd_en_out = link_up_in;
            learn_en_out = link_up_in;
        end
        else
        begin
            fwd_en_out = (state == STP_FORWARDING);
            learn_en_out = (state == STP_FORWARDING) || (state == STP_LEARNING);
        end
    end

endmodule

`default_nettype wire

// File: hdl/stp_hello_gate.sv
// Purpose: spaces configuration frame transmissions by the hello time
// Assumes: tx request is a one-cycle pulse
// Notes: first request after reset is granted at once
`include "stp_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module stp_hello_gate #(
    parameter int TICK_CYCLES = `STP_TICK_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] hello_s_in,
    input wire logic tx_req_in,
    output logic tx_grant_out
);

    logic [31:0] tick;
    logic [31:0] next_tick;
    logic [7:0] elapsed;
    logic [7:0] next_elapsed;
    logic grant;
    logic next_grant;
    logic tick_done;

    assign tick_done = (tick == 32'(TICK_CYCLES - 1));

    always_comb
    begin
        next_tick = tick_done ? 32'h0000_0000 : tick + 32'h0000_0001;
        next_elapsed = elapsed;
        next_grant = 1'b0;
        if (tx_req_in && (elapsed >= hello_s_in))
        begin
            next_grant = 1'b1;
            next_elapsed = 8'h00;
            next_tick = 32'h0000_0000;
        end
        else if (tick_done && (elapsed != 8'hFF))
        begin
            next_elapsed = elapsed + 8'h01;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tick <= 32'h0000_0000;
            elapsed <= 8'hFF;
            grant <= 1'b0;
        end
        else
        begin
            tick <= next_tick;
            elapsed <= next_elapsed;
            grant <= next_grant;
        end
    end

    assign tx_grant_out = grant;

endmodule

`default_nettype wire

// File: test/stp_peer_model.sv
// Purpose: far side of the state gate: link levels and frame requests
// Assumes: the bench commands every change
// Notes: outputs lag the commands by one cycle
`timescale 1ns/1ns
`default_nettype none
module stp_peer_model (
    input wire logic core_clk_in,
    input wire logic [7:0] link_cmd_in,
    input wire logic [7:0] p2p_cmd_in,
    input wire logic send_cmd_in,
    output logic [7:0] link_up_out,
    output logic [7:0] p2p_out,
    output logic tx_req_out
);
    // ----
    // levels
    // ----
    // defined from time zero so the gate never sees an unknown link
    initial
    begin
        link_up_out = 8'hFF;
        p2p_out = 8'h00;
        tx_req_out = 1'b0;
    end
    always @(posedge core_clk_in)
    begin
        link_up_out <= link_cmd_in;
        p2p_out <= p2p_cmd_in;
        tx_req_out <= send_cmd_in;
    end
endmodule
`default_nettype wire

// File: test/stp_gate_asserts.sv
// Purpose: port checks of the spanning tree state gate
// Assumes: port 0 keeps spanning tree enabled
// Notes: bound to every gate instance
`timescale 1ns/1ns
`default_nettype none
module stp_gate_asserts #(
    parameter int NUM_PORTS = 8
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic [NUM_PORTS-1:0] link_up_in,
    input wire logic bpdu_tx_req_in,
    input wire logic bpdu_tx_grant_out,
    input wire logic [3*NUM_PORTS-1:0] port_state_out,
    input wire logic [NUM_PORTS-1:0] fwd_en_out,
    input wire logic [NUM_PORTS-1:0] learn_en_out
);
    // ----
    // checks
    // ----
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    logic [2:0] st;
    logic up;
    assign st = port_state_out[2:0];
    assign up = link_up_in[0];
    property p_down;
        !up |=> st == 3'h0;
    endproperty
    property p_quiet;
        (st == 3'h1 || st == 3'h2) |-> !fwd_en_out[0] && !learn_en_out[0];
    endproperty
    property p_learn;
        st == 3'h3 && up |-> !fwd_en_out[0] && learn_en_out[0];
    endproperty
    property p_fwd;
        st == 3'h4 && up |-> fwd_en_out[0] && learn_en_out[0];
    endproperty
    // only one step up the ladder, or a drop to disabled
    property p_step;
        st != $past(st) |-> st == 3'h0 || st == $past(st) + 3'h1;
    endproperty
    property p_rst;
        $rose(rst_n_in) |-> port_state_out == {NUM_PORTS{3'h1}};
    endproperty
    property p_grant;
        bpdu_tx_grant_out |-> $past(bpdu_tx_req_in);
    endproperty
    property p_rdy;
        psel_in && penable_in |-> pready_out;
    endproperty
    a_down: assert property (p_down)
        else $error("port not disabled after link loss");
    a_quiet: assert property (p_quiet)
        else $error("blocked port passes or learns");
    a_learn: assert property (p_learn)
        else $error("learning port wrong enables");
    a_fwd: assert property (p_fwd)
        else $error("forwarding port wrong enables");
    a_step: assert property (p_step)
        else $error("illegal state step");
    a_rst: assert property (p_rst)
        else $error("ports not blocking out of reset");
    a_grant: assert property (p_grant)
        else $error("grant without request");
    a_rdy: assert property (p_rdy)
        else $error("apb access not answered");
    c_fwd: cover property (st == 3'h4);
    c_down: cover property (st == 3'h0);
    c_grant: cover property (bpdu_tx_grant_out);
endmodule
bind stp_gate stp_gate_asserts #(.NUM_PORTS(NUM_PORTS)) chk_u (
    .core_clk_in, .rst_n_in, .psel_in, .penable_in, .pready_out, .link_up_in,
    .bpdu_tx_req_in, .bpdu_tx_grant_out, .port_state_out, .fwd_en_out, .learn_en_out
);
`default_nettype wire

// File: test/stp_gate_tb.sv
// Purpose: self-checking bench of the spanning tree state gate
// Assumes: zero-wait apb slave, one second shortened to 10 cycles
// Notes: outputs are looked at 1 ns after an edge to dodge update races
`timescale 1ns/1ns
`default_nettype none
module stp_gate_tb;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, send, req, grant;
    logic steady, is_root, rerr;
    logic [7:0] paddr, link_cmd, p2p_cmd, link, p2p, fwd, learn, edge_fl, p2p_fl;
    logic [31:0] pwdata, prdata, rdata;
    logic [23:0] st;
    logic [3:0] hint;
    logic [63:0] own_id, root_ident;
    int fails, checks, grants;
    logic [2:0] rq [7] = '{3'h4, 3'h2, 3'h4, 3'h3, 3'h1, 3'h4, 3'h1};
    logic [2:0] ex [7] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4};
    logic [7:0] ra [5] = '{8'h00, 8'h0C, 8'h30, 8'h40, 8'h10};
    logic [31:0] rv [5] = '{32'hFF, 32'h8000, 32'h2, 32'h4, 32'h0};
    stp_peer_model peer_u (.core_clk_in(clk), .link_cmd_in(link_cmd), .p2p_cmd_in(p2p_cmd),
        .send_cmd_in(send), .link_up_out(link), .p2p_out(p2p), .tx_req_out(req));
    stp_gate #(.TICK_CYCLES(10)) dut_u (.core_clk_in(clk), .rst_n_in(rst_n),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
        .link_up_in(link), .point_to_point_link_flag_in(p2p), .bpdu_tx_req_in(req),
        .bpdu_tx_grant_out(grant), .port_state_out(st), .fwd_en_out(fwd),
        .learn_en_out(learn), .edge_port_out(edge_fl), .point_to_point_link_flag_out(p2p_fl),
        .own_bridge_identifier_out(own_id), .tree_root_identifier_out(root_ident),
        .topo_steady_out(steady), .is_root_out(is_root), .block_valid_out(hint[3]),
        .block_port_out(hint[2:0]));
    // ----
    // tasks
    // ----
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse;
        @(posedge clk);
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
    endtask
    task automatic ids(input logic [7:0] b);
        apb(1'b1, b, 32'h1234);
        apb(1'b1, b + 8'h04, 32'hABCD);
        apb(1'b1, b + 8'h08, 32'h0123_4567);
        look(1);
    endtask
    task close_out;
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ----
    // run
    // ----
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
        if (grant === 1'b1)
            grants++;
    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        close_out();
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, send, paddr, pwdata, p2p_cmd} = '0;
        link_cmd = 8'hFF;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        look(1);
        chk("states", 24'h249249, st);
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, ra[i], 32'h0);
            chk("reset value", rv[i], rdata);
        end
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped error", 1'b1, rerr);
        // illegal jumps alternate with legal ones so a held state is visible
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, 8'h04, {29'h0, rq[i]});
            look(2);
            chk("state", ex[i], st[2:0]);
            chk("forward", ex[i] == 3'h4, fwd[0]);
            chk("learn", ex[i] >= 3'h3, learn[0]);
        end
        apb(1'b0, 8'h34, 32'h0);
        chk("status", 32'h0301_01FF, rdata);
        chk("hint", 4'h8, hint);
        @(posedge clk);
        link_cmd <= 8'hFE;
        look(3);
        chk("state", 3'h0, st[2:0]);
        apb(1'b0, 8'h08, 32'h0);
        chk("state reg", 32'h0024_9248, rdata);
        apb(1'b1, 8'h04, 32'h1);
        look(2);
        chk("state", 3'h0, st[2:0]);
        @(posedge clk);
        link_cmd <= 8'hFF;
        apb(1'b1, 8'h04, 32'h2);
        look(2);
        chk("state", 3'h0, st[2:0]);
        apb(1'b1, 8'h04, 32'h1);
        look(2);
        chk("state", 3'h1, st[2:0]);
        apb(1'b1, 8'h00, 32'h7F);
        look(1);
        chk("forward off", 1'b1, fwd[7]);
        chk("forward on", 1'b0, fwd[6]);
        apb(1'b1, 8'h28, 32'h5A);
        apb(1'b0, 8'h28, 32'h0);
        chk("edge reg", 32'h5A, rdata);
        chk("edge port", 8'h5A, edge_fl);
        @(posedge clk);
        p2p_cmd <= 8'hA5;
        look(3);
        chk("link type", 8'hA5, p2p_fl);
        apb(1'b0, 8'h2C, 32'h0);
        chk("link type reg", 32'hA5, rdata);
        ids(8'h0C);
        chk("own id", 64'h1234_ABCD_0123_4567, own_id);
        chk("is root", 1'b0, is_root);
        ids(8'h18);
        chk("root ident", 64'h1234_ABCD_0123_4567, root_ident);
        chk("is root", 1'b1, is_root);
        apb(1'b1, 8'h24, 32'h1);
        look(1);
        chk("steady", 1'b0, steady);
        apb(1'b0, 8'h24, 32'h0);
        chk("topology reg", 32'h1, rdata);
        apb(1'b1, 8'h24, 32'h0);
        look(1);
        chk("steady", 1'b1, steady);
        // hello is 2 s: the second request comes too early
        pulse();
        pulse();
        look(40);
        pulse();
        look(4);
        chk("grants", 2, grants);
        close_out();
    end
endmodule
`default_nettype wire
